// *** logic/cps_supervisor.sv ***
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cps_supervisor
    import cps_pkg::*;
#(
    parameter int SHIP_DLY_CYC = CPS_SHIP_DLY_CYC,
    parameter int INT_PULSE_CYC = CPS_INT_PULSE_CYC,
    parameter int RETRY_GAP_CYC = CPS_RETRY_GAP_CYC
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous comparator inputs.
    input wire logic input_overvolt_event,
    input wire logic system_overvolt_event,
    input wire logic boost_short_event,
    input wire logic boost_overvolt_event,
    input wire logic temp_reg_hot,
    input wire logic temp_shut_hot,
    input wire logic temp_shut_cool,
    input wire logic battery_overvolt_event,
    input wire logic battery_depleted,
    input wire logic battery_below_short,
    input wire logic battery_below_low,
    input wire logic battery_above_min_sys,
    input wire logic sys_below_bat_180,
    input wire logic sys_below_bat_45,
    input wire logic battery_overcurrent,
    input wire logic min_sys_regulating,
    input wire logic input_current_over,
    input wire logic input_voltage_under,
    input wire logic input_present,
    // Actions toward the power stage.
    output logic buck_switch_en,
    output logic boost_switch_en,
    output logic battery_switch_on,
    output logic sys_discharge_en,
    output logic charge_en,
    output logic charge_current_reduce,
    output logic termination_block,
    output logic timer_half_rate,
    output logic short_current_sel,
    output logic precharge_current_sel,
    output logic [2:0] input_overvolt_sel,
    // Open-drain interrupt, low pulse.
    output logic int_out,
    output logic int_oe
);
    localparam int NSYNC = 19;
    localparam logic [2:0] RETRY_MAX = 3'(CPS_BOOST_RETRIES);

    // Three-stage synchronisers; a change counts when stages two and three agree.
    logic [NSYNC-1:0] raw_in, s1_q, s2_q, s3_q, filt_q;
    assign raw_in = {input_overvolt_event, system_overvolt_event, boost_short_event, boost_overvolt_event,
                     temp_reg_hot, temp_shut_hot, temp_shut_cool, battery_overvolt_event, battery_depleted,
                     battery_below_short, battery_below_low, battery_above_min_sys, sys_below_bat_180,
                     sys_below_bat_45, battery_overcurrent, min_sys_regulating, input_current_over,
                     input_voltage_under, input_present};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        end
    end

    logic in_ov, sys_ov, b_short, b_ov, t_reg, t_shut, t_cool, bat_ov, bat_dpl, bat_sh, bat_low;
    logic bat_above_min, sup180, sup45, bat_oc, minsys, i_over, v_under, in_pres;
    assign {in_ov, sys_ov, b_short, b_ov, t_reg, t_shut, t_cool, bat_ov, bat_dpl, bat_sh, bat_low,
            bat_above_min, sup180, sup45, bat_oc, minsys, i_over, v_under, in_pres} = filt_q;

    // Rising-edge events from the filtered levels.
    logic [NSYNC-1:0] prev_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= filt_q;
        end
    end
    logic [NSYNC-1:0] rise;
    assign rise = filt_q & ~prev_q;
    logic rise_in_ov, rise_b_short, rise_b_ov, rise_t_shut, rise_bat_ov, rise_in_pres, rise_bat_dpl;
    assign rise_in_ov = rise[18];
    assign rise_b_short = rise[16];
    assign rise_b_ov = rise[15];
    assign rise_t_shut = rise[13];
    assign rise_bat_ov = rise[11];
    assign rise_bat_dpl = rise[10];
    assign rise_in_pres = rise[0];

    // APB decode; zero-wait slave.
    logic wr_acc, rd_acc;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    logic ctrl_wr, fault_rd;
    assign ctrl_wr = wr_acc && (paddr == CPS_CTRL_OFS);
    assign fault_rd = rd_acc && (paddr == CPS_FAULT_OFS);

    // Boost retry sequencer.
    logic boost_giveup, boost_off_ev;
    logic [2:0] retry_q;
    logic [7:0] gap_q;
    logic retry_wait_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            retry_q <= '0;
            gap_q <= '0;
            retry_wait_q <= 1'b0;
        end else if (ctrl_wr && pwdata[CPS_CTRL_BOOST_EN]) begin
            retry_q <= '0;
            retry_wait_q <= 1'b0;
        end else if (rise_b_short && !retry_wait_q) begin
            retry_wait_q <= 1'b1;
            gap_q <= 8'(RETRY_GAP_CYC);
        end else if (retry_wait_q) begin
            if (gap_q != 8'h00) begin
                gap_q <= gap_q - 8'h01;
            end else begin
                retry_wait_q <= 1'b0;
                retry_q <= retry_q + 3'h1;
            end
        end
    end
    assign boost_giveup = rise_b_short && !retry_wait_q && (retry_q == RETRY_MAX);

    // Boost turn-off events: retry give-up, boost overvoltage, or thermal shutdown while boost is enabled.
    logic boost_tshut_q, buck_tshut_q, boost_en_q;
    assign boost_off_ev = boost_giveup || rise_b_ov || (rise_t_shut && boost_en_q);

    // Control register: boost enable, switch disable, shipping delay, input overvoltage select.
    logic bsw_dis_q, ship_dly_q;
    logic [2:0] ovsel_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            boost_en_q <= 1'b0;
            bsw_dis_q <= 1'b0;
            ship_dly_q <= 1'b0;
            ovsel_q <= CPS_OVSEL_RST;
        end else begin
            if (ctrl_wr) begin
                boost_en_q <= pwdata[CPS_CTRL_BOOST_EN];
                bsw_dis_q <= pwdata[CPS_CTRL_BSW_DIS];
                ship_dly_q <= pwdata[CPS_CTRL_SHIP_DLY];
                ovsel_q <= pwdata[CPS_CTRL_OVSEL_LSB +: 3];
            end
            if (boost_off_ev) begin
                boost_en_q <= 1'b0;
            end
            if (rise_in_pres) begin
                bsw_dis_q <= 1'b0;
            end
        end
    end
    assign input_overvolt_sel = ovsel_q;

    // Thermal shutdown latches, released only when the cool comparator shows hysteresis passed.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            buck_tshut_q <= 1'b0;
            boost_tshut_q <= 1'b0;
        end else begin
            if (rise_t_shut && !boost_en_q) begin
                buck_tshut_q <= 1'b1;
            end else if (t_cool) begin
                buck_tshut_q <= 1'b0;
            end
            if (rise_t_shut && boost_en_q) begin
                boost_tshut_q <= 1'b1;
            end else if (t_cool) begin
                boost_tshut_q <= 1'b0;
            end
        end
    end

    // Over-discharge and overcurrent latches.
    logic odis_q, ocl_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            odis_q <= 1'b0;
            ocl_q <= 1'b0;
        end else begin
            // Taken on the depletion edge, so a replug with a still low battery allows recovery charge.
            if (rise_bat_dpl) begin
                odis_q <= 1'b1;
            end else if (rise_in_pres) begin
                odis_q <= 1'b0;
            end
            if (bat_oc) begin
                ocl_q <= 1'b1;
            end else if (rise_in_pres || (ctrl_wr && !pwdata[CPS_CTRL_BSW_DIS] && bsw_dis_q)) begin
                ocl_q <= 1'b0;
            end
        end
    end

    // Shipping-mode delay counter.
    logic ship_off_q;
    logic [31:0] ship_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ship_off_q <= 1'b0;
            ship_cnt_q <= '0;
        end else if (!bsw_dis_q) begin
            ship_off_q <= 1'b0;
            ship_cnt_q <= '0;
        end else if (!ship_dly_q || ship_cnt_q >= 32'(SHIP_DLY_CYC)) begin
            ship_off_q <= 1'b1;
        end else begin
            ship_cnt_q <= ship_cnt_q + 32'h1;
        end
    end

    // Supplement mode: select the threshold by battery versus minimum system.
    logic suppl_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            suppl_q <= 1'b0;
        end else if (bat_dpl) begin
            suppl_q <= 1'b0;
        end else if (bat_above_min ? sup180 : sup45) begin
            suppl_q <= 1'b1;
        end else begin
            suppl_q <= 1'b0;
        end
    end

    // Fault register: code and battery bits held until read, boost bit until a boost enable write; set wins over the clear.
    logic [1:0] code_q;
    logic bat_flt_q, boost_flt_q, held_q, int_req;
    logic new_fault;
    assign new_fault = rise_in_ov || rise_bat_ov || boost_giveup || rise_b_ov || (rise_t_shut && !boost_en_q);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            code_q <= CPS_CODE_NONE;
            bat_flt_q <= 1'b0;
            boost_flt_q <= 1'b0;
            held_q <= 1'b0;
        end else begin
            if (fault_rd) begin
                code_q <= in_ov ? CPS_CODE_INOV : (buck_tshut_q ? CPS_CODE_TSHUT : CPS_CODE_NONE);
                bat_flt_q <= bat_ov;
                held_q <= 1'b0;
            end
            if (fault_rd && !boost_flt_q) begin
                boost_flt_q <= 1'b0;
            end
            if (ctrl_wr && pwdata[CPS_CTRL_BOOST_EN]) begin
                boost_flt_q <= 1'b0;
            end
            if (rise_in_ov) begin
                code_q <= CPS_CODE_INOV;
            end else if (rise_t_shut && !boost_en_q) begin
                code_q <= CPS_CODE_TSHUT;
            end
            if (rise_bat_ov) begin
                bat_flt_q <= 1'b1;
            end
            if (boost_giveup || rise_b_ov) begin
                boost_flt_q <= 1'b1;
            end
            if (new_fault) begin
                held_q <= 1'b1;
            end
        end
    end
    assign int_req = new_fault && (!held_q || fault_rd);

    // Interrupt pulse stretcher: one low pulse of fixed length.
    logic [15:0] int_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_cnt_q <= '0;
        end else if (int_req && int_cnt_q == 16'h0000) begin
            int_cnt_q <= 16'(INT_PULSE_CYC);
        end else if (int_cnt_q != 16'h0000) begin
            int_cnt_q <= int_cnt_q - 16'h0001;
        end
    end
    assign int_out = 1'b0;
    assign int_oe = (int_cnt_q != 16'h0000);

    // Power stage actions.
    logic bsw_q, buck_q, boost_q, dis_q, chg_q, red_q, trm_q, half_q, shc_q, prc_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bsw_q <= 1'b0;
            buck_q <= 1'b0;
            boost_q <= 1'b0;
            dis_q <= 1'b0;
            chg_q <= 1'b0;
            red_q <= 1'b0;
            trm_q <= 1'b0;
            half_q <= 1'b0;
            shc_q <= 1'b0;
            prc_q <= 1'b0;
        end else begin
            buck_q <= in_pres && !in_ov && !sys_ov && !buck_tshut_q && !boost_en_q;
            boost_q <= boost_en_q && !retry_wait_q && !b_short && !b_ov && !boost_tshut_q;
            dis_q <= sys_ov;
            bsw_q <= !buck_tshut_q && !boost_tshut_q && !odis_q && !ocl_q && !ship_off_q
                     && (in_pres || suppl_q || !bat_dpl);
            chg_q <= in_pres && !bat_ov && !buck_tshut_q && !in_ov;
            red_q <= t_reg || i_over || v_under;
            trm_q <= t_reg || i_over || v_under;
            half_q <= t_reg;
            shc_q <= bat_sh;
            prc_q <= !bat_sh && bat_low;
        end
    end
    assign buck_switch_en = buck_q;
    assign boost_switch_en = boost_q;
    assign battery_switch_on = bsw_q;
    assign sys_discharge_en = dis_q;
    assign charge_en = chg_q;
    assign charge_current_reduce = red_q;
    assign termination_block = trm_q;
    assign timer_half_rate = half_q;
    assign short_current_sel = shc_q;
    assign precharge_current_sel = prc_q;

    // Read mux; unmapped offsets read zero.
    logic [31:0] stat_word;
    assign stat_word = {22'h00_0000, boost_q, buck_q, ocl_q, odis_q, suppl_q, bsw_q,
                        i_over, v_under, minsys, t_reg};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CPS_CTRL_OFS: prdata <= {25'h000_0000, ovsel_q, 1'b0, ship_dly_q, bsw_dis_q, boost_en_q};
                CPS_STAT_OFS: prdata <= stat_word;
                CPS_FAULT_OFS: prdata <= {28'h000_0000, boost_flt_q, bat_flt_q, code_q};
                CPS_RAW_OFS: prdata <= {13'h0000, filt_q};
                default: prdata <= '0;
            endcase
        end
    end
endmodule : cps_supervisor

// *** logic/cps_pkg.sv ***
package cps_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] CPS_CTRL_OFS = 8'h00;
    localparam logic [7:0] CPS_STAT_OFS = 8'h04;
    localparam logic [7:0] CPS_FAULT_OFS = 8'h08;
    localparam logic [7:0] CPS_RAW_OFS = 8'h0C;
    // Control register fields.
    localparam int CPS_CTRL_BOOST_EN = 0;
    localparam int CPS_CTRL_BSW_DIS = 1;
    localparam int CPS_CTRL_SHIP_DLY = 2;
    localparam int CPS_CTRL_OVSEL_LSB = 4;
    localparam logic [2:0] CPS_OVSEL_RST = 3'h1;
    // Status register fields.
    localparam int CPS_STAT_THERM = 0;
    localparam int CPS_STAT_MINSYS = 1;
    localparam int CPS_STAT_VLIM = 2;
    localparam int CPS_STAT_ILIM = 3;
    localparam int CPS_STAT_BSW_ON = 4;
    localparam int CPS_STAT_SUPPL = 5;
    localparam int CPS_STAT_ODIS = 6;
    localparam int CPS_STAT_OCL = 7;
    localparam int CPS_STAT_BUCK_RUN = 8;
    localparam int CPS_STAT_BOOST_RUN = 9;
    // Fault register fields.
    localparam int CPS_FLT_CODE_LSB = 0;
    localparam int CPS_FLT_BAT = 2;
    localparam int CPS_FLT_BOOST = 3;
    localparam logic [1:0] CPS_CODE_NONE = 2'b00;
    localparam logic [1:0] CPS_CODE_INOV = 2'b01;
    localparam logic [1:0] CPS_CODE_TSHUT = 2'b10;
    // Analog thresholds, for reference by the comparator side.
    localparam int CPS_SYSOV_ABOVE_MIN_MV = 350;
    localparam int CPS_SUPPL_HI_MV = 180;
    localparam int CPS_SUPPL_LO_MV = 45;
    localparam int CPS_TREG_C = 110;
    localparam int CPS_TSHUT_C = 160;
    localparam int CPS_TSHUT_HYS_C = 30;
    localparam int CPS_BATOV_PCT = 4;
    localparam int CPS_ISHORT_MA = 100;
    // Timing.
    localparam int CPS_CLK_HZ = 25_000_000;
    localparam int CPS_INT_PULSE_US = 256;
    localparam int CPS_INT_PULSE_CYC = CPS_INT_PULSE_US * (CPS_CLK_HZ / 1_000_000);
    localparam int CPS_BOOST_RETRIES = 7;
    localparam int CPS_RETRY_GAP_CYC = 64;
    localparam int CPS_SHIP_DLY_CYC = 250_000_000;
endpackage : cps_pkg

// *** tb/cps_supervisor_monitor.sv ***
`timescale 1ns/1ps
module cps_supervisor_monitor
    import cps_pkg::*;
#(
    parameter int INT_PULSE_CYC = CPS_INT_PULSE_CYC
) (
    // Clock, reset and bus.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Comparators.
    input wire logic input_overvolt_event,
    input wire logic system_overvolt_event,
    input wire logic boost_overvolt_event,
    input wire logic battery_overvolt_event,
    input wire logic temp_reg_hot,
    // Actions.
    input wire logic buck_switch_en,
    input wire logic boost_switch_en,
    input wire logic battery_switch_on,
    input wire logic sys_discharge_en,
    input wire logic charge_en,
    input wire logic charge_current_reduce,
    input wire logic timer_half_rate,
    input wire logic [2:0] input_overvolt_sel,
    input wire logic int_out,
    input wire logic int_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic wr_ctrl;
    int unsigned low_q;
    // A control write that lands at this edge.
    assign wr_ctrl = psel && penable && pwrite && paddr == CPS_CTRL_OFS;
    // Counts the cycles that the interrupt pin has been pulled low.
    always_ff @(posedge ref_clk) begin
        low_q <= (rst_n && int_oe) ? low_q + 1 : 0;
    end
    a_bus_no_wait: assert property (psel |-> pready && !pslverr) else $error("Bus slave stalled or flagged.");
    a_ovsel_follow: assert property (wr_ctrl |=> input_overvolt_sel == $past(pwdata[6:4]))
        else $error("Overvoltage select does not follow the control write.");
    a_inov_stop: assert property (input_overvolt_event [*8] |-> !buck_switch_en)
        else $error("Buck still switching in input overvoltage.");
    a_sysov_sink: assert property (system_overvolt_event [*8] |-> sys_discharge_en && !buck_switch_en)
        else $error("System overvoltage not clamped.");
    a_boost_ov_stop: assert property (boost_overvolt_event [*8] |-> !boost_switch_en)
        else $error("Boost still switching in overvoltage.");
    a_batov_stop: assert property (battery_overvolt_event [*8] |-> !charge_en)
        else $error("Charging still on in battery overvoltage.");
    a_therm_reduce: assert property (temp_reg_hot [*8] ##0 !boost_switch_en |-> charge_current_reduce && timer_half_rate)
        else $error("Thermal regulation actions missing.");
    a_int_width: assert property ($fell(int_oe) |-> low_q == INT_PULSE_CYC)
        else $error("Interrupt pulse has the wrong width.");
    a_int_low: assert property (int_oe |-> !int_out)
        else $error("Interrupt pin driven high.");
    a_ship_now: assert property (wr_ctrl && pwdata[2:1] == 2'b01 |-> ##[1:4] !battery_switch_on)
        else $error("Battery switch not off after immediate disable.");
    c_int: cover property ($rose(int_oe));
    c_boost_off: cover property ($fell(boost_switch_en));
    c_sink: cover property ($rose(sys_discharge_en));
endmodule : cps_supervisor_monitor
bind cps_supervisor cps_supervisor_monitor #(.INT_PULSE_CYC(INT_PULSE_CYC)) u_mon (.*);

// *** tb/cps_host_model.sv ***
`timescale 1ns/1ps
module cps_host_model (
    // Clock.
    input wire logic ref_clk,
    // Bus master.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Interrupt pin level, pulled up.
    input wire logic int_pin
);
    int n_pulse = 0;
    int width_q = 0;
    int run_q = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // Measures each low pulse on the interrupt pin and counts them.
    always @(posedge ref_clk) begin
        if (int_pin !== 1'b1) begin
            run_q <= run_q + 1;
        end else if (run_q != 0) begin
            n_pulse <= n_pulse + 1;
            width_q <= run_q;
            run_q <= 0;
        end
    end
    // One transfer: setup, then access until ready; boost re-enable, switch disable and
    // repeated fault reads all go through here.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cps_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import cps_pkg::*;
    localparam int PW = 16;
    localparam int SD = 20;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [18:0] cmp = '0;
    logic psel, penable, pwrite, pready, pslverr, int_out, int_oe, int_pin, b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic buck_switch_en, boost_switch_en, battery_switch_on, sys_discharge_en, charge_en;
    logic charge_current_reduce, termination_block, timer_half_rate, short_current_sel, precharge_current_sel;
    logic [2:0] input_overvolt_sel;
    int n_fail = 0;
    int n_compared = 0;
    int exp_ctrl = 32'h0000_0010;
    int exp_int = 0;
    int lv[$] = '{4, 15, 17, 16};
    int sb[$] = '{CPS_STAT_THERM, CPS_STAT_MINSYS, CPS_STAT_VLIM, CPS_STAT_ILIM};
    always #20 ref_clk = ~ref_clk;
    // Open-drain interrupt wire with its pull-up.
    assign int_pin = int_oe ? int_out : 1'b1;
    cps_supervisor #(.SHIP_DLY_CYC(SD), .INT_PULSE_CYC(PW), .RETRY_GAP_CYC(4)) u_dut (
        .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .input_overvolt_event(cmp[0]), .system_overvolt_event(cmp[1]), .boost_short_event(cmp[2]),
        .boost_overvolt_event(cmp[3]), .temp_reg_hot(cmp[4]), .temp_shut_hot(cmp[5]), .temp_shut_cool(cmp[6]),
        .battery_overvolt_event(cmp[7]), .battery_depleted(cmp[8]), .battery_below_short(cmp[9]),
        .battery_below_low(cmp[10]), .battery_above_min_sys(cmp[11]), .sys_below_bat_180(cmp[12]),
        .sys_below_bat_45(cmp[13]), .battery_overcurrent(cmp[14]), .min_sys_regulating(cmp[15]),
        .input_current_over(cmp[16]), .input_voltage_under(cmp[17]), .input_present(cmp[18]),
        .buck_switch_en, .boost_switch_en, .battery_switch_on, .sys_discharge_en, .charge_en,
        .charge_current_reduce, .termination_block, .timer_half_rate, .short_current_sel,
        .precharge_current_sel, .input_overvolt_sel, .int_out, .int_oe);
    cps_host_model u_host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .int_pin);
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // Reads a register and compares the masked value.
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] g;
        u_host.xfer(1'b0, a, 32'h0000_0000, g);
        n_compared++;
        if ((g & m) !== e) begin
            n_fail++;
            $display("[FAIL] %0t reg %h read %h expected %h", $time, a, g, e);
        end
    endtask : chk_reg
    // Compares one level with its expected value.
    task automatic chk_pin(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t level %b expected %b", $time, g, e);
        end
    endtask : chk_pin
    task automatic wr(input int d);
        logic [31:0] g;
        exp_ctrl = d;
        u_host.xfer(1'b1, CPS_CTRL_OFS, 32'(d), g);
    endtask : wr
    task automatic pulse(input int i);
        cmp[i] <= 1'b1;
        tick(8);
        cmp[i] <= 1'b0;
        tick(8);
    endtask : pulse
    // Expects exactly one more interrupt pulse of the set width.
    task automatic exp_irq();
        tick(PW + 8);
        exp_int++;
        chk_pin(u_host.n_pulse == exp_int && u_host.width_q == PW, 1'b1);
    endtask : exp_irq
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // Watchdog against a hang.
    initial begin
        tick(20000);
        n_fail++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        int r;
        r = $urandom(32'h0598_a822);
        cmp[6] <= 1'b1;
        cmp[18] <= 1'b1;
        tick(4);
        rst_n <= 1'b1;
        chk_reg(CPS_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0010);
        chk_reg(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        r = $urandom % 8;
        wr(r << 4);
        tick(8);
        chk_pin(input_overvolt_sel === 3'(r), 1'b1);
        b = buck_switch_en;
        cmp[0] <= 1'b1;
        tick(8);
        chk_pin(buck_switch_en, 1'b0);
        exp_irq();
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h1);
        cmp[0] <= 1'b0;
        tick(8);
        chk_pin(buck_switch_en, b);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h1);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h0);
        wr(exp_ctrl | 1);
        for (int i = 0; i < CPS_BOOST_RETRIES; i++) begin
            pulse(2);
            chk_pin(boost_switch_en, 1'b1);
            chk_reg(CPS_CTRL_OFS, 32'h1, 32'h1);
        end
        pulse(2);
        chk_reg(CPS_CTRL_OFS, 32'hFFFF_FFFF, exp_ctrl & ~1);
        exp_irq();
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h8);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h8);
        wr(exp_ctrl | 1);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h0);
        pulse(3);
        chk_reg(CPS_CTRL_OFS, 32'hFFFF_FFFF, exp_ctrl & ~1);
        exp_irq();
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h8);
        wr(exp_ctrl | 1);
        wr(exp_ctrl & ~1);
        cmp[6] <= 1'b0;
        cmp[5] <= 1'b1;
        tick(8);
        chk_pin(buck_switch_en | battery_switch_on, 1'b0);
        exp_irq();
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h2);
        cmp[5] <= 1'b0;
        tick(8);
        chk_pin(buck_switch_en | battery_switch_on, 1'b0);
        cmp[6] <= 1'b1;
        tick(8);
        chk_pin(buck_switch_en, b);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h2);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h0);
        wr(exp_ctrl | 1);
        b = battery_switch_on;
        cmp[6] <= 1'b0;
        cmp[5] <= 1'b1;
        tick(8);
        chk_reg(CPS_CTRL_OFS, 32'h1, 32'h0);
        chk_pin(battery_switch_on, 1'b0);
        cmp[5] <= 1'b0;
        cmp[6] <= 1'b1;
        tick(PW + 8);
        chk_pin(battery_switch_on, b);
        exp_ctrl = exp_ctrl & ~1;
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h0);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h0);
        chk_pin(u_host.n_pulse == exp_int, 1'b1);
        cmp[7] <= 1'b1;
        tick(8);
        chk_pin(charge_en, 1'b0);
        exp_irq();
        cmp[7] <= 1'b0;
        pulse(0);
        tick(PW);
        chk_pin(u_host.n_pulse == exp_int, 1'b1);
        chk_reg(CPS_FAULT_OFS, 32'h4, 32'h4);
        chk_reg(CPS_FAULT_OFS, 32'hF, 32'h0);
        for (int i = 0; i < 4; i++) begin
            cmp[lv[i]] <= 1'b1;
            tick(8);
            chk_reg(CPS_STAT_OFS, 32'(1) << sb[i], 32'(1) << sb[i]);
            chk_pin(charge_current_reduce, lv[i] != 15);
            chk_pin(termination_block, lv[i] != 15);
            cmp[lv[i]] <= 1'b0;
            tick(8);
            chk_reg(CPS_STAT_OFS, 32'(1) << sb[i], 32'h0);
        end
        cmp[1] <= 1'b1;
        tick(8);
        chk_pin(sys_discharge_en & !buck_switch_en, 1'b1);
        cmp[1] <= 1'b0;
        cmp[11] <= 1'b1;
        cmp[12] <= 1'b1;
        tick(8);
        chk_reg(CPS_STAT_OFS, 32'h30, 32'h30);
        cmp[8] <= 1'b1;
        tick(8);
        chk_pin(battery_switch_on, 1'b0);
        cmp[8] <= 1'b0;
        cmp[12] <= 1'b0;
        cmp[18] <= 1'b0;
        tick(8);
        cmp[18] <= 1'b1;
        tick(8);
        chk_reg(CPS_STAT_OFS, 32'h40, 32'h0);
        cmp[9] <= 1'b1;
        cmp[10] <= 1'b1;
        tick(8);
        chk_pin(short_current_sel & !precharge_current_sel, 1'b1);
        cmp[9] <= 1'b0;
        tick(8);
        chk_pin(precharge_current_sel & !short_current_sel, 1'b1);
        cmp[10] <= 1'b0;
        wr(exp_ctrl | 2);
        tick(4);
        chk_pin(battery_switch_on, 1'b0);
        wr(exp_ctrl & ~2);
        wr(exp_ctrl | 6);
        tick(4);
        chk_pin(battery_switch_on, 1'b1);
        tick(SD + 4);
        chk_pin(battery_switch_on, 1'b0);
        pulse(14);
        chk_reg(CPS_STAT_OFS, 32'h90, 32'h80);
        wr(exp_ctrl & ~6);
        tick(4);
        chk_reg(CPS_STAT_OFS, 32'h80, 32'h0);
        end_of_test();
    end
endmodule : tb_top
